// ==== hw/rtdp_pkg.sv ====
// Shared constants, types and exponent helper for the rx/tx port timing block
package rtdp_pkg;

    // Data widths of the converter ports, then register bus address and data widths
    localparam int RX_W = 12;
    localparam int TX_W = 14;
    localparam int AW   = 8;
    localparam int DW   = 32;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CLK  = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;

    // Control register field positions
    localparam int CB_ADC_HALF  = 0;
    localparam int CB_RX_INV    = 1;
    localparam int CB_RX_RETIME = 2;
    localparam int CB_DECIM     = 3;
    localparam int CB_MUX       = 4;
    localparam int CB_RXM_INV   = 5;
    localparam int CB_TX_RETIME = 6;
    localparam int CB_TX_FALL   = 7;
    localparam int CB_TX_DUAL_E = 8;
    localparam int CB_IQ_ORDER  = 9;
    localparam int CB_TXM_INV   = 10;
    localparam int CB_TX_2CH    = 11;
    localparam int CTRL_W       = 12;

    // Clock register fields: multiplier and divider codes are log2 values
    localparam int CK_MULT_LSB = 0;
    localparam int CK_DIV_LSB  = 2;
    localparam int CK_W        = 4;

    // Status register field positions
    localparam int SB_ALT_MODE = 0;
    localparam int SB_CAPTURED = 1;
    localparam int SB_RX_SEL   = 2;

    // Reset values and the alternative-mode multiplier default
    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
    localparam logic [1:0]        MULT_1X  = 2'h0;
    localparam logic [1:0]        MULT_4X  = 2'h2;
    localparam logic [1:0]        DIV_RST  = 2'h0;
    localparam logic [DW-1:0]     RD_ZERO  = 32'h0000_0000;

    // Reference clock half period is 2**REF_HALF_EXP mclk cycles
    localparam logic [2:0] REF_HALF_EXP = 3'h2;
    localparam logic [2:0] EXP_ZERO     = 3'h0;
    localparam logic [2:0] EXP_ONE      = 3'h1;

    // Synchroniser depth for pin inputs
    localparam logic [1:0] SYNC_STAGES = 2'h2;

    // Clock generator slots
    localparam int N_CLK  = 3;
    localparam int CK_RX  = 0;
    localparam int CK_TX  = 1;
    localparam int CK_ADC = 2;

    // Rx output sequencer states
    typedef enum logic [1:0]
    {
        RTDP_OUT_A = 2'b01,
        RTDP_OUT_B = 2'b10
    } rtdp_seq_e;

    // Half-period exponent: base plus up minus down, floored at zero
    function automatic logic [2:0] rtdp_exp
    (
        input logic [2:0] base,
        input logic [2:0] up,
        input logic [1:0] down
    );
        logic [3:0] sum;
        sum = {1'b0, base} + {1'b0, up};
        if (sum > {2'b00, down})
            rtdp_exp = 3'(sum - {2'b00, down});
        else
            rtdp_exp = EXP_ZERO;
    endfunction

endpackage

// ==== hw/rtdp_clk_if.sv ====
// Carrier between the timing core and one clock generator
`timescale 1ns/1ns
interface rtdp_clk_if;
    logic [2:0] half_exp;  // Half period is 2**half_exp cycles
    logic       clk_lvl;   // Generated clock level
    logic       rise;      // Pulse as the level goes high
    logic       fall;      // Pulse as the level goes low

    modport gen  (input half_exp, output clk_lvl, rise, fall);
    modport user (output half_exp, input clk_lvl, rise, fall);
endinterface

// ==== hw/rtdp_clkgen.sv ====
// Programmable divider giving a clock level and edge pulses
`timescale 1ns/1ns
module rtdp_clkgen
(
    input wire logic   mclk,
    input wire logic   rstn,
    rtdp_clk_if.gen    cif
);
    import rtdp_pkg::*;

    logic [5:0] cnt_ff;   // Cycles spent in current half period
    logic       lvl_ff;   // Clock level
    logic       rise_ff;  // Rising edge pulse
    logic       fall_ff;  // Falling edge pulse
    logic [5:0] limit;    // Last count of a half period

    // Compare with >= so a shrinking period never stalls the counter
    assign limit = 6'((32'h0000_0001 << cif.half_exp) - 32'h0000_0001);

    // Divider counter and edge pulses
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_ff  <= 6'h00;
            lvl_ff  <= 1'b0;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end
        else if (cnt_ff >= limit)
        begin
            cnt_ff  <= 6'h00;
            lvl_ff  <= ~lvl_ff;
            rise_ff <= ~lvl_ff;
            fall_ff <= lvl_ff;
        end
        else
        begin
            cnt_ff  <= 6'(cnt_ff + 6'h01);
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end
    end

    assign cif.clk_lvl = lvl_ff;
    assign cif.rise    = rise_ff;
    assign cif.fall    = fall_ff;

endmodule

// ==== hw/rtdp_core.sv ====
// Rx/tx data port timing: mode strap, clock derivation, rx mux, tx demux
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
// How it works
// (R1) Strap low gives normal, else alternative mode
// (R2) Alternative mode defaults loop multiplier to four
// (R3) Normal: tx from loop, rx ignores multiplier
// (R4) Alternative: rx and tx clocks from loop
// (R5) Normal: sample rate reference or half
// (R6) Rx clock half reference when select low
// (R7) Rx clock invert swaps latching edges
// (R8) Rx data timed to rx clock unless retimed
// (R9) Decimation halves rate; mux interleaves onto A
// (R10) Mux marker high for A, invert swaps
// (R11) Tx data on tx clock unless retimed
// (R12) Tx latch on rising, falling or both
// (R13) Two-channel tx multiplexed on bus, demultiplexed here
// (R14) Normal tx clock: ref*mult/div, halved on half-rate
// (R15) Tx pair routed I-Q or Q-I order
// (R16) Tx marker low for A, invert reverses
// (R17) System should prefer normal mode for jitter
// (R18) Alternative: sample rate loop clock or half
// (R19) Alternative: tx clock ignores half-rate select
// (R20) Captured mode held until next reset
module rtdp_core
(
    input  wire logic                    mclk,
    input  wire logic                    rstn,
    input  wire logic [rtdp_pkg::AW-1:0] addr,
    input  wire logic [rtdp_pkg::DW-1:0] wdata,
    input  wire logic                    wr_stb,
    input  wire logic                    rd_stb,
    output logic      [rtdp_pkg::DW-1:0] rdata,
    input  wire logic                    timing_mode_strap,
    input  wire logic                    rx_clock_rate_select,
    input  wire logic [rtdp_pkg::RX_W-1:0] adc_a,
    input  wire logic [rtdp_pkg::RX_W-1:0] adc_b,
    output logic                         adc_sample,
    output logic                         rx_output_clock,
    output logic      [rtdp_pkg::RX_W-1:0] rx_data_a,
    output logic      [rtdp_pkg::RX_W-1:0] rx_data_b,
    output logic                         rx_channel_marker,
    output logic                         tx_input_clock,
    input  wire logic [rtdp_pkg::TX_W-1:0] tx_data,
    input  wire logic                    tx_channel_marker,
    output logic      [rtdp_pkg::TX_W-1:0] tx_i,
    output logic      [rtdp_pkg::TX_W-1:0] tx_q,
    output logic                         tx_valid
);
    import rtdp_pkg::*;

    // Software registers
    logic [CTRL_W-1:0] ctrl_ff;      // Mode and option bits
    logic [1:0]        mult_ff;      // Loop multiplier, log2
    logic [1:0]        div_ff;       // Tx clock divider, log2
    logic [DW-1:0]     rdata_ff;     // Read data, one cycle late

    // Pin synchronisers
    logic              strap_s1_ff;
    logic              strap_s2_ff;
    logic              sel_s1_ff;
    logic              sel_s2_ff;
    logic              txm_s1_ff;
    logic              txm_s2_ff;
    logic [TX_W-1:0]   txd_s1_ff;
    logic [TX_W-1:0]   txd_s2_ff;

    // Mode capture
    logic [1:0]        sync_cnt_ff;  // Cycles since reset release
    logic              captured_ff;  // Strap has been taken
    logic              alt_mode_ff;  // Alternative timing mode

    // Clock generators
    rtdp_clk_if        cif [N_CLK] ();
    logic              rx_clk_ff;    // Rx output clock pin
    logic              tx_clk_ff;    // Tx input clock pin
    logic              adc_smp_ff;   // Converter sample strobe

    // Rx path
    logic              decim_ph_ff;  // Decimation phase
    logic [RX_W-1:0]   hold_a_ff;    // Latest accepted A sample
    logic [RX_W-1:0]   hold_b_ff;    // Latest accepted B sample
    rtdp_seq_e         seq_ff;       // Mux output slot
    logic [RX_W-1:0]   rxd_a_ff;
    logic [RX_W-1:0]   rxd_b_ff;
    logic              rxm_ff;
    logic              rx_upd;       // Rx output update event
    logic              smp_take;     // Sample kept after decimation

    // Tx path
    logic [1:0]        lat_dly_ff;   // Latch pulse aligned to sync delay
    logic              lat_now;      // Latch event on source clock
    logic              chan_b;       // Bus word belongs to channel B
    logic [TX_W-1:0]   tx_hold_ff;   // Channel A word awaiting its pair
    logic [TX_W-1:0]   tx_i_ff;
    logic [TX_W-1:0]   tx_q_ff;
    logic              tx_vld_ff;

    // Clock generator instances
    genvar gi;
    generate
        for (gi = 0; gi < N_CLK; gi++)
        begin : g_clk
            rtdp_clkgen u_gen
            (
                .mclk (mclk),
                .rstn (rstn),
                .cif  (cif[gi].gen)
            );
        end
    endgenerate

    // Rx clock: reference or half, loop only in alternative mode
    assign cif[CK_RX].half_exp = rtdp_exp(REF_HALF_EXP,
        sel_s2_ff ? EXP_ZERO : EXP_ONE,                        // R6
        alt_mode_ff ? mult_ff : MULT_1X);                      // R3 R4

    // Tx clock: ref*mult/div, half-rate only in normal mode
    assign cif[CK_TX].half_exp = rtdp_exp(REF_HALF_EXP,
        3'({1'b0, div_ff} + {2'b00, ctrl_ff[CB_ADC_HALF]      // R14
            & ~alt_mode_ff}),                                  // R19
        mult_ff);                                              // R3 R4

    // Converter sample clock: reference or loop, optionally halved
    assign cif[CK_ADC].half_exp = rtdp_exp(REF_HALF_EXP,
        {2'b00, ctrl_ff[CB_ADC_HALF]},                         // R5 R18
        alt_mode_ff ? mult_ff : MULT_1X);                      // R18

    // Pin synchronisers, first stage read only by second
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            strap_s1_ff <= 1'b0;
            strap_s2_ff <= 1'b0;
            sel_s1_ff   <= 1'b0;
            sel_s2_ff   <= 1'b0;
            txm_s1_ff   <= 1'b0;
            txm_s2_ff   <= 1'b0;
            txd_s1_ff   <= '0;
            txd_s2_ff   <= '0;
        end
        else
        begin
            strap_s1_ff <= timing_mode_strap;
            strap_s2_ff <= strap_s1_ff;
            sel_s1_ff   <= rx_clock_rate_select;
            sel_s2_ff   <= sel_s1_ff;
            txm_s1_ff   <= tx_channel_marker;
            txm_s2_ff   <= txm_s1_ff;
            txd_s1_ff   <= tx_data;
            txd_s2_ff   <= txd_s1_ff;
        end
    end

    // Strap capture once the synchroniser holds a real pin value
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync_cnt_ff <= 2'h0;
            captured_ff <= 1'b0;
            alt_mode_ff <= 1'b0;
        end
        else if (!captured_ff)
        begin
            if (sync_cnt_ff == SYNC_STAGES)
            begin
                captured_ff <= 1'b1;
                alt_mode_ff <= strap_s2_ff;                    // R1
            end
            else
                sync_cnt_ff <= 2'(sync_cnt_ff + 2'h1);
        end
        // Mode frozen after capture until reset                  R20
    end

    // Control register
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            ctrl_ff <= CTRL_RST;
        else if (wr_stb && addr == ADDR_CTRL)
            ctrl_ff <= wdata[CTRL_W-1:0];
    end

    // Clock register; mode capture loads the multiplier default
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            mult_ff <= MULT_1X;
            div_ff  <= DIV_RST;
        end
        else if (!captured_ff && sync_cnt_ff == SYNC_STAGES)
            mult_ff <= strap_s2_ff ? MULT_4X : MULT_1X;        // R2
        else if (wr_stb && addr == ADDR_CLK)
        begin
            // Code 3 is not a valid multiplier; keep four
            mult_ff <= (wdata[CK_MULT_LSB+1:CK_MULT_LSB] > MULT_4X)
                       ? MULT_4X : wdata[CK_MULT_LSB+1:CK_MULT_LSB];
            div_ff  <= (wdata[CK_DIV_LSB+1:CK_DIV_LSB] > MULT_4X)
                       ? MULT_4X : wdata[CK_DIV_LSB+1:CK_DIV_LSB];
        end
    end

    // Read port: data only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rdata_ff <= RD_ZERO;
        else if (rd_stb)
        begin
            case (addr)
                ADDR_CTRL: rdata_ff <= DW'(ctrl_ff);
                ADDR_CLK:  rdata_ff <= DW'({div_ff, mult_ff});
                ADDR_STAT: rdata_ff <= DW'({sel_s2_ff, captured_ff,
                                            alt_mode_ff});
                default:   rdata_ff <= RD_ZERO;
            endcase
        end
        else
            rdata_ff <= RD_ZERO;
    end

    // Output clock pins and sample strobe
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_clk_ff  <= 1'b0;
            tx_clk_ff  <= 1'b0;
            adc_smp_ff <= 1'b0;
        end
        else
        begin
            rx_clk_ff  <= cif[CK_RX].clk_lvl
                          ^ ctrl_ff[CB_RX_INV];                // R7
            tx_clk_ff  <= cif[CK_TX].clk_lvl;
            adc_smp_ff <= cif[CK_ADC].rise;
        end
    end

    // Rx update edge: away from latching edge, or on tx clock if retimed
    assign rx_upd = ctrl_ff[CB_RX_RETIME] ? cif[CK_TX].fall      // R8
                  : (ctrl_ff[CB_RX_INV] ? cif[CK_RX].rise      // R7
                                        : cif[CK_RX].fall);
    assign smp_take = cif[CK_ADC].rise
                      && (!ctrl_ff[CB_DECIM] || !decim_ph_ff); // R9

    // Sample capture with optional decimation
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            decim_ph_ff <= 1'b0;
            hold_a_ff   <= '0;
            hold_b_ff   <= '0;
        end
        else
        begin
            if (cif[CK_ADC].rise)
                decim_ph_ff <= ~decim_ph_ff & ctrl_ff[CB_DECIM];
            if (smp_take)
            begin
                hold_a_ff <= adc_a;
                hold_b_ff <= adc_b;
            end
        end
    end

    // Rx output buses, mux sequencer and channel marker
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            seq_ff   <= RTDP_OUT_A;
            rxd_a_ff <= '0;
            rxd_b_ff <= '0;
            rxm_ff   <= 1'b0;
        end
        else if (rx_upd)
        begin
            if (ctrl_ff[CB_MUX])
            begin
                case (seq_ff)                                  // R9
                    RTDP_OUT_A:
                    begin
                        rxd_a_ff <= hold_a_ff;
                        rxm_ff   <= ~ctrl_ff[CB_RXM_INV];      // R10
                        seq_ff   <= RTDP_OUT_B;
                    end
                    RTDP_OUT_B:
                    begin
                        rxd_a_ff <= hold_b_ff;
                        rxm_ff   <= ctrl_ff[CB_RXM_INV];       // R10
                        seq_ff   <= RTDP_OUT_A;
                    end
                    default:
                        seq_ff   <= RTDP_OUT_A;
                endcase
            end
            else
            begin
                rxd_a_ff <= hold_a_ff;
                rxd_b_ff <= hold_b_ff;
                rxm_ff   <= 1'b0;
                seq_ff   <= RTDP_OUT_A;
            end
        end
    end

    // Tx latch event on the chosen source clock and edges
    always_comb
    begin
        logic src_r;
        logic src_f;
        src_r = ctrl_ff[CB_TX_RETIME] ? cif[CK_RX].rise         // R11
                                      : cif[CK_TX].rise;
        src_f = ctrl_ff[CB_TX_RETIME] ? cif[CK_RX].fall
                                      : cif[CK_TX].fall;
        if (ctrl_ff[CB_TX_DUAL_E])
            lat_now = src_r | src_f;                           // R12
        else if (ctrl_ff[CB_TX_FALL])
            lat_now = src_f;                                   // R12
        else
            lat_now = src_r;                                   // R12
    end

    // Marker polarity: low means channel A unless inverted
    assign chan_b = txm_s2_ff ^ ctrl_ff[CB_TXM_INV];           // R16

    // Delay latch event to meet data through its synchroniser
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            lat_dly_ff <= 2'b00;
        else
            lat_dly_ff <= {lat_dly_ff[0], lat_now};
    end

    // Tx demultiplexer and I/Q routing
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_hold_ff <= '0;
            tx_i_ff    <= '0;
            tx_q_ff    <= '0;
            tx_vld_ff  <= 1'b0;
        end
        else if (lat_dly_ff[1])
        begin
            if (!ctrl_ff[CB_TX_2CH])
            begin
                tx_i_ff   <= txd_s2_ff;
                tx_vld_ff <= 1'b1;
            end
            else if (!chan_b)
            begin
                tx_hold_ff <= txd_s2_ff;                       // R13
                tx_vld_ff  <= 1'b0;
            end
            else if (ctrl_ff[CB_IQ_ORDER])
            begin
                tx_i_ff   <= txd_s2_ff;                        // R15
                tx_q_ff   <= tx_hold_ff;
                tx_vld_ff <= 1'b1;
            end
            else
            begin
                tx_i_ff   <= tx_hold_ff;                       // R15
                tx_q_ff   <= txd_s2_ff;
                tx_vld_ff <= 1'b1;
            end
        end
        else
            tx_vld_ff <= 1'b0;
    end

    // Ports straight from flip-flops
    assign rdata             = rdata_ff;
    assign adc_sample        = adc_smp_ff;
    assign rx_output_clock   = rx_clk_ff;
    assign rx_data_a         = rxd_a_ff;
    assign rx_data_b         = rxd_b_ff;
    assign rx_channel_marker = rxm_ff;
    assign tx_input_clock    = tx_clk_ff;
    assign tx_i              = tx_i_ff;
    assign tx_q              = tx_q_ff;
    assign tx_valid          = tx_vld_ff;

    // Checks on the timing core
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Capture step: captured_ff low, then high
    sequence s_capture;
        !captured_ff ##1 captured_ff;
    endsequence

    sequence s_b_latch;
        lat_dly_ff[1] && ctrl_ff[CB_TX_2CH] && chan_b;
    endsequence

    a_mode_hold: assert property (captured_ff |=> $stable(alt_mode_ff)) // R20
        else $error("timing mode changed after capture");
    a_strap_take: assert property (s_capture |-> // R1
        alt_mode_ff == $past(strap_s2_ff))
        else $error("captured mode differs from strap");
    a_alt_mult: assert property (s_capture ##0 alt_mode_ff // R2
        |-> mult_ff == MULT_4X)
        else $error("alternative mode multiplier not four");
    a_rx_rate: assert property (!alt_mode_ff |-> // R6
        cif[CK_RX].half_exp == (sel_s2_ff ? 3'h2 : 3'h3))
        else $error("rx clock rate wrong in normal mode");
    a_tx_normal: assert property (!alt_mode_ff && div_ff == 2'h2 // R14
        && mult_ff == MULT_1X && ctrl_ff[CB_ADC_HALF]
        |-> cif[CK_TX].half_exp == 3'h5)
        else $error("tx clock not reference over eight");
    a_tx_alt: assert property (alt_mode_ff |-> // R19
        cif[CK_TX].half_exp == rtdp_exp(REF_HALF_EXP,
            {1'b0, div_ff}, mult_ff))
        else $error("half-rate select moved tx clock");
    a_adc_rate: assert property (!alt_mode_ff |-> // R5
        cif[CK_ADC].half_exp == (ctrl_ff[CB_ADC_HALF] ? 3'h3 : 3'h2))
        else $error("sample rate wrong in normal mode");
    a_rx_clk_inv: assert property (##1 rx_clk_ff == // R7
        ($past(cif[CK_RX].clk_lvl) ^ $past(ctrl_ff[CB_RX_INV])))
        else $error("rx clock invert not applied");
    a_rx_marker: assert property (rx_upd && ctrl_ff[CB_MUX] // R10
        && seq_ff == RTDP_OUT_A |=> rxm_ff == ~$past(ctrl_ff[CB_RXM_INV])
        && rxd_a_ff == $past(hold_a_ff))
        else $error("rx marker does not flag channel A");
    a_tx_pair: assert property (s_b_latch |=> tx_vld_ff && // R15
        tx_q_ff == ($past(ctrl_ff[CB_IQ_ORDER]) ? $past(tx_hold_ff)
                                                : $past(txd_s2_ff)))
        else $error("tx pair not routed in chosen order");

endmodule

// ==== test/rtdp_asic_model.sv ====
// Far-side baseband model feeding paired tx words
`timescale 1ns/1ns
module rtdp_asic_model
(
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    input  wire logic                      tx_input_clock,
    output logic      [rtdp_pkg::TX_W-1:0] tx_data,
    output logic                           tx_channel_marker
);
    import rtdp_pkg::*;
    logic        prev_ff;  // Last seen tx clock level
    logic [11:0] k_ff;     // Pair counter
    // New word after each falling tx clock edge; A tagged 01, B tagged 10
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_ff           <= 1'b0;
            k_ff              <= 12'h000;
            tx_data           <= 14'h0000;
            tx_channel_marker <= 1'b1;
        end
        else
        begin
            prev_ff <= tx_input_clock;
            if (prev_ff && !tx_input_clock)
            begin
                tx_channel_marker <= !tx_channel_marker;
                if (tx_channel_marker)
                    tx_data <= {2'h1, k_ff};
                else
                begin
                    tx_data <= {2'h2, k_ff};
                    k_ff    <= k_ff + 12'h001;
                end
            end
        end
    end
endmodule

// ==== test/rx_tx_data_port_timing_test.sv ====
// Self-checking bench for the rx/tx port timing core
`timescale 1ns/1ns
module rx_tx_data_port_timing_test;
    import rtdp_pkg::*;
    logic mclk, rstn, wr_stb, rd_stb, strap, sel, adc_sample;
    logic rx_clk, rx_mark, tx_clk, tx_mark, tx_valid;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   wdata, rdata;
    logic [RX_W-1:0] rx_a, rx_b;
    logic [TX_W-1:0] tx_data, tx_i, tx_q;
    int error_cnt = 0;
    int n_checks  = 0;
    int cyc       = 0;
    logic [7:0] adc_n = 8'h00;
    rtdp_core dut_u (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .timing_mode_strap(strap), .rx_clock_rate_select(sel),
        .adc_a({4'hA, adc_n}), .adc_b({4'h5, adc_n}), .adc_sample(adc_sample),
        .rx_output_clock(rx_clk), .rx_data_a(rx_a), .rx_data_b(rx_b),
        .rx_channel_marker(rx_mark), .tx_input_clock(tx_clk),
        .tx_data(tx_data), .tx_channel_marker(tx_mark), .tx_i(tx_i),
        .tx_q(tx_q), .tx_valid(tx_valid));
    rtdp_asic_model far_u (.mclk(mclk), .rstn(rstn), .tx_input_clock(tx_clk),
        .tx_data(tx_data), .tx_channel_marker(tx_mark));
    // Clock and hang guard
    always #5 mclk = !mclk;
    // Converter inputs step once per sample pulse
    always @(posedge mclk)
    begin
        if (adc_sample)
            adc_n <= adc_n + 8'h01;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        n_checks++;
        if (got !== e)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, e);
        end
    endtask
    // Bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a; wdata <= d; wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a; rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // Reset with a given strap level, then let the strap move
    task automatic rst(input logic s);
        rstn <= 1'b0; strap <= s;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        repeat (6) @(posedge mclk);
        strap <= !s;
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? rx_clk : (s == 1 ? tx_clk : adc_sample);
    endfunction
    task automatic up(input int s, output int g);
        g = 0;
        while (pick(s) !== 1'b0 && g < 99) begin @(posedge mclk); g++; end
        while (pick(s) !== 1'b1 && g < 99) begin @(posedge mclk); g++; end
    endtask
    // Cycles between rising edges of one generated clock
    task automatic period(input int s, input int e);
        int g;
        repeat (20) @(posedge mclk);
        up(s, g);
        up(s, g);
        chk(32'(g), 32'(e));
    endtask
    // Paired tx words: lane tags of tx_i and tx_q
    task automatic tx_case(input logic [31:0] c, input logic [3:0] e);
        int g;
        wr(ADDR_CTRL, c);
        for (int i = 0; i < 4; i++)
        begin
            g = 0;
            @(posedge mclk);
            while (tx_valid !== 1'b1 && g < 500) begin @(posedge mclk); g++; end
            if (i > 1)
                chk({28'h0, tx_i[13:12], tx_q[13:12]}, {28'h0, e});
        end
    endtask
    // Muxed rx bus follows the channel marker
    task automatic rx_case(input logic [31:0] c, input logic v);
        logic s0, s1;
        s0 = 1'b0; s1 = 1'b0;
        wr(ADDR_CTRL, c);
        repeat (100) @(posedge mclk);
        repeat (40)
        begin
            @(posedge mclk);
            s0 = s0 | !rx_mark; s1 = s1 | rx_mark;
            chk({28'h0, rx_a[11:8]}, (rx_mark ^ v) ? 32'hA : 32'h5);
        end
        chk({30'h0, s0, s1}, 32'h3);
    endtask
    // Plain rx buses: sample step per update, B beside A, marker low
    task automatic rx_plain(input logic [31:0] c, input logic [7:0] d);
        logic [7:0] p;
        wr(ADDR_CTRL, c);
        repeat (100) @(posedge mclk);
        repeat (3)
        begin
            p = rx_a[7:0];
            while (rx_a[7:0] == p) @(posedge mclk);
            chk({24'h0, 8'(rx_a[7:0] - p)}, {24'h0, d});
            chk({19'h0, rx_mark, rx_b}, {20'h0, 4'h5, rx_a[7:0]});
        end
    endtask
    initial
    begin
        mclk = 0; rstn = 0; wr_stb = 0; rd_stb = 0; addr = 0; wdata = 0;
        strap = 0; sel = 0;
        rst(1'b0);
        rd(ADDR_STAT, 32'h2);
        rd(ADDR_CLK, 32'h0);
        rd(8'h0C, 32'h0);
        period(0, 16);
        sel <= 1'b1;
        period(0, 8);
        wr(ADDR_CLK, 32'h2);
        period(1, 2);
        period(0, 8);
        period(2, 8);
        wr(ADDR_CTRL, 32'h1);
        period(1, 4);
        period(2, 16);
        wr(ADDR_CLK, 32'h8);
        tx_case(32'h800, 4'h6);
        tx_case(32'hA00, 4'h9);
        tx_case(32'hC00, 4'h9);
        tx_case(32'h880, 4'h6);
        tx_case(32'h940, 4'h6);
        rx_case(32'h10, 1'b0);
        rx_case(32'h30, 1'b1);
        rx_plain(32'h0, 8'h1);
        rx_plain(32'h8, 8'h2);
        rx_plain(32'h4, 8'h4);
        rx_plain(32'h2, 8'h1);
        rst(1'b1);
        rd(ADDR_STAT, 32'h7);
        rd(ADDR_CLK, 32'h2);
        period(0, 2);
        period(1, 2);
        wr(ADDR_CTRL, 32'h1);
        period(1, 2);
        period(2, 4);
        finish_test();
    end
endmodule
